// ==== bench/lss_meas_model.sv ====
`timescale 1ns/100ps
// Far side: function block signals and the sample tick
module lss_meas_model
	import lss_pkg::*;
#(
	parameter int TPER = 4                // Cycles between ticks
)
(
	input  wire logic             clk_i,  // System clock
	output logic                  tick_o, // Sample tick pulse
	output lss_pkg::lss_meas_type meas_o  // All block signals
);
	int cnt = 0;                          // Tick divider

	// Known values from time zero
	initial
	begin
		tick_o = 1'b0;
		meas_o = '0;
	end

	// Free-running tick keeps sampling regular, as a filter would
	always @(posedge clk_i)
	begin
		tick_o <= (cnt == TPER - 1);
		cnt    <= (cnt == TPER - 1) ? 0 : cnt + 1;
	end

	// New value lands just after an edge, at least one cycle before the tick that samples it
	task set_val(input int b, input int s, input int v);
		@(posedge clk_i);
		meas_o[b][s] <= v[15:0];
	endtask : set_val
endmodule : lss_meas_model

// ==== bench/lss_top_props.sv ====
`timescale 1ns/100ps
// Port-level checks on the supervisor bank
module lss_top_props
	import lss_pkg::*;
(
	input wire logic            clk_i,    // System clock
	input wire logic            rst_i,    // Synchronous reset
	input wire logic            wb_cyc_i, // Bus cycle
	input wire logic            wb_stb_i, // Bus strobe
	input wire logic            wb_we_i,  // Write enable
	input wire logic [11:0]     wb_adr_i, // Byte address
	input wire logic [31:0]     wb_dat_o, // Read data
	input wire logic            wb_ack_o, // Acknowledge
	input wire logic [NSUP-1:0] status_o, // Qualified status
	input wire logic [31:0]     disp_o,   // Display slots
	input wire logic [NOUT-1:0] dout_o    // Digital outputs
);
	// ****************************************************
	// Bus and status relations
	// ****************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_timed: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without request");
	chk_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack while idle");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 12'h400
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	chk_status_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h200 &&
		$stable(status_o) |-> wb_dat_o == status_o) else $error("status word mismatch");
	chk_disp_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h204 &&
		$stable(disp_o) |-> wb_dat_o == disp_o) else $error("display word mismatch");
	chk_disp_status: assert property (disp_o != 32'h0 |-> status_o != '0)
		else $error("display set with no status");
	chk_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && status_o == '0 &&
		disp_o == 32'h0 && dout_o == '0) else $error("outputs not clear after reset");
endmodule : lss_top_props

// ==== bench/tb_lss_top.sv ====
`timescale 1ns/100ps
// Self-checking bench for the supervisor bank
module tb_lss_top;
	import lss_pkg::*;
	// ****************************************************
	// Signals
	// ****************************************************
	logic             clk_i;           // Clock
	logic             rst_i;           // Reset
	logic             cyc, stb, we;    // Bus control
	logic [11:0]      adr;             // Bus address
	logic [31:0]      dat;             // Write data
	logic [3:0]       sel;             // Byte enables
	logic [31:0]      dat_o;           // Read data
	logic             ack;             // Acknowledge
	logic             tick;            // Sample tick
	lss_meas_type     meas;            // Block signals
	logic [NSUP-1:0]  status;          // Status word
	logic [31:0]      disp;            // Display word
	logic [NOUT-1:0]  dout;            // Digital outputs
	logic [31:0]      rd;              // Last read value
	int               err_count = 0;   // Mismatches
	int               check_count = 0; // Comparisons

	lss_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .tick_i(tick), .meas_i(meas), .status_o(status), .disp_o(disp),
		.dout_o(dout));
	lss_meas_model #(.TPER(4)) m (.clk_i(clk_i), .tick_o(tick), .meas_o(meas));

	// ****************************************************
	// Shared tasks
	// ****************************************************
	task ck(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : ck

	// One classic cycle; the master never assumes the slave's latency
	task wbx(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wbx

	task rdc(input logic [11:0] a, input logic [31:0] e);
		wbx(1'b0, a, 32'h0, 4'hf);
		ck(rd, e);
	endtask : rdc

	// All four settings words of one supervisor; down delay is zero unless given
	task sup(input int i, input logic [2:0] sr, input logic [3:0] b, input logic ab,
		input logic pl, input logic [15:0] lv, input logic [15:0] hy, input logic [15:0] up,
		input logic [15:0] dn = 16'h0);
		wbx(1'b1, 12'(i * 16), {22'h0, pl, ab, b, 1'b0, sr}, 4'hf);
		wbx(1'b1, 12'(i * 16 + 4), {16'h0, lv}, 4'hf);
		wbx(1'b1, 12'(i * 16 + 8), {16'h0, hy}, 4'hf);
		wbx(1'b1, 12'(i * 16 + 12), {dn, up}, 4'hf);
	endtask : sup

	// Count ticks, then let the registered outputs settle
	task tk(input int n);
		repeat (n) @(posedge clk_i iff tick);
		repeat (2) @(posedge clk_i);
		#1;
	endtask : tk

	task step(input int b, input int s, input int v, input logic e, input int i = 0);
		m.set_val(b, s, v);
		tk(1);
		ck(status[i], e);
	endtask : step

	// ****************************************************
	// Scenarios
	// ****************************************************
	task t_bus;
		rdc(12'h000, 32'h0);
		rdc(12'h200, 32'h0);
		wbx(1'b1, 12'h004, 32'h8001, 4'h3);
		rdc(12'h004, 32'hffff8001);
		wbx(1'b1, 12'h004, 32'h00ff, 4'h1);
		rdc(12'h004, 32'hffff80ff);
		rdc(12'h400, 32'h0);
		wbx(1'b1, 12'h200, 32'hffffffff, 4'hf);
		rdc(12'h200, 32'h0);
	endtask : t_bus

	// Band above the level, then below it; equality holds
	task t_hyst;
		sup(0, 3'h1, 4'h1, 1'b0, 1'b0, 16'd100, 16'd20, 16'h0);
		step(0, 0, 90, 1'b0);
		step(0, 0, 110, 1'b0);
		step(0, 0, 121, 1'b1);
		step(0, 0, 100, 1'b1);
		step(0, 0, 99, 1'b0);
		wbx(1'b1, 12'h008, 32'hffec, 4'hf);
		step(0, 0, 101, 1'b1);
		step(0, 0, 81, 1'b1);
		step(0, 0, 79, 1'b0);
	endtask : t_hyst

	// Hysteresis kept at zero while delays are used
	task t_delay;
		sup(0, 3'h1, 4'h1, 1'b0, 1'b0, 16'd100, 16'd0, 16'd3, 16'd2);
		step(0, 0, 150, 1'b0);
		tk(2);
		ck(status[0], 1'b0);
		tk(1);
		ck(status[0], 1'b1);
		step(0, 0, 50, 1'b1);
		step(0, 0, 150, 1'b1);
		step(0, 0, 50, 1'b1);
		tk(1);
		ck(status[0], 1'b1);
		tk(1);
		ck(status[0], 1'b0);
	endtask : t_delay

	task t_abs;
		sup(0, 3'h1, 4'h1, 1'b1, 1'b0, 16'd100, 16'd0, 16'h0);
		step(0, 0, -150, 1'b1);
		step(0, 0, -50, 1'b0);
		wbx(1'b1, 12'h004, 32'hffff, 4'hf);
		step(0, 0, -32768, 1'b1);
	endtask : t_abs

	// Source and block choice, disabled codes, last supervisor
	task t_sel;
		sup(0, 3'h2, 4'h8, 1'b0, 1'b0, 16'd100, 16'd0, 16'h0);
		step(7, 1, 150, 1'b1);
		step(7, 1, 50, 1'b0);
		step(7, 1, 150, 1'b1);
		wbx(1'b1, 12'h000, 32'h080, 4'hf);
		tk(1);
		ck(status[0], 1'b0);
		wbx(1'b1, 12'h000, 32'h092, 4'hf);
		tk(1);
		ck(status[0], 1'b0);
		sup(31, 3'h1, 4'h1, 1'b0, 1'b0, 16'd100, 16'd0, 16'h0);
		step(0, 0, 150, 1'b1, 31);
	endtask : t_sel

	task t_out;
		sup(0, 3'h1, 4'h1, 1'b0, 1'b0, 16'd100, 16'd0, 16'h0);
		wbx(1'b1, 12'h300, 32'h100, 4'hf);
		tk(1);
		ck(dout[0], 1'b1);
		ck(disp[3:0], 4'h3);
		rdc(12'h204, 32'h3);
		rdc(12'h200, 32'h80000001);
		wbx(1'b1, 12'h000, 32'h211, 4'hf);
		tk(1);
		ck(dout[0], 1'b0);
		ck(status[0], 1'b1);
	endtask : t_out

	// ****************************************************
	// Clock, reset, sequence and verdict
	// ****************************************************
	task stop_test;
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// 100 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Main sequence
	initial
	begin
		{cyc, stb, we, adr, dat, sel} = '0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_bus;
		t_hyst;
		t_delay;
		t_abs;
		t_sel;
		t_out;
		stop_test;
	end

	// Hang guard, far beyond the few hundred cycles expected
	initial
	begin
		#300000;
		err_count++;
		stop_test;
	end
endmodule : tb_lss_top

bind lss_top lss_top_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .status_o(status_o), .disp_o(disp_o), .dout_o(dout_o));

// ==== rtl/lss_pkg.sv ====
// Function
// - Thirty-two independent supervisors, own settings and status
// - Unused source disables supervisor, no status, output
// - Compare the measurement chosen by source selection
// - Function block one to eight supplies signal
// - Absolute mode compares signal magnitude against level
// - Absolute mode, negative level: always above
// - Polarity picks output active above or below
// - Signed hysteresis: negative below, positive above
// - One threshold at level, other offset by hysteresis
// - Rise only after staying above whole up delay
// - Fall only after staying below whole down delay
// - Status bit is the qualified above/below result
// - Status independent of attached digital output state
// - Show first four supervisors of each block
// - Digital output follows connected supervisor with polarity
package lss_pkg;

	// ****************************************************
	// Sizes
	// ****************************************************
	localparam int NSUP = 32;                  // Supervisors
	localparam int NBLK = 8;                   // Function blocks
	localparam int NSRC = 4;                   // Signals per block
	localparam int NOUT = 8;                   // Digital outputs
	localparam int DISP_PER_BLK = 4;           // Display slots per block

	// ****************************************************
	// Register word indices (byte address = 4 x index)
	// ****************************************************
	localparam logic [9:0] IDX_SUP_LAST = 10'h07f; // Four words per supervisor
	localparam logic [1:0] FLD_CFG      = 2'h0;    // Source, block, mode, polarity
	localparam logic [1:0] FLD_LEVEL    = 2'h1;    // Signed level
	localparam logic [1:0] FLD_HYST     = 2'h2;    // Signed hysteresis
	localparam logic [1:0] FLD_DELAY    = 2'h3;    // Up and down delays in ticks
	localparam logic [9:0] IDX_STATUS   = 10'h080; // Qualified status word
	localparam logic [9:0] IDX_DISP     = 10'h081; // Display status word
	localparam logic [9:0] IDX_OSEL     = 10'h0c0; // First output connect word

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int CFG_SRC_LSB = 0;            // Three bits, 0 = not in use
	localparam int CFG_BLK_LSB = 4;            // Four bits, 1 to 8
	localparam int CFG_ABS_BIT = 8;            // Absolute mode
	localparam int CFG_POL_BIT = 9;            // 1 = output active below
	localparam int DLY_DN_LSB  = 16;           // Down delay above up delay
	localparam int OSEL_EN_BIT = 8;            // Output connected

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000; // All settings cleared

	// ****************************************************
	// Types
	// ****************************************************
	typedef logic [NBLK-1:0][NSRC-1:0][15:0] lss_meas_type; // All signals

	typedef struct packed {
		logic        [2:0]  src;    // Signal source, 0 = unused
		logic        [3:0]  blk;    // Function block number
		logic               absm;   // Absolute comparison
		logic               pol;    // Output active below level
		logic signed [15:0] level;  // Set level
		logic signed [15:0] hyst;   // Signed hysteresis width
		logic        [15:0] up_dly; // Rising delay, ticks
		logic        [15:0] dn_dly; // Falling delay, ticks
	} lss_sup_type;

	typedef struct packed {
		logic       en;             // Output connected
		logic [4:0] idx;            // Supervisor driving it
	} lss_osel_type;

endpackage : lss_pkg

// ==== rtl/lss_sel.sv ====
`timescale 1ns/100ps
// Picks one supervised signal out of all function blocks
module lss_sel
	import lss_pkg::*;
(
	input  wire lss_pkg::lss_meas_type meas_i, // All measurement signals
	input  wire logic [2:0]            src_i,  // Source selection
	input  wire logic [3:0]            blk_i,  // Function block 1 to 8
	output logic signed [15:0]         val_o,  // Chosen signal
	output logic                       ok_o    // Selection is valid
);
	// Block and source numbers count from one in the settings
	wire [3:0] blk_n = blk_i - 4'h1;
	wire [2:0] src_n = src_i - 3'h1;

	// Out of range values leave the supervisor disabled
	assign ok_o  = (src_i != 3'h0) && (src_i <= 3'(NSRC)) &&
		(blk_i != 4'h0) && (blk_i <= 4'(NBLK));
	assign val_o = ok_o ? meas_i[blk_n[2:0]][src_n[1:0]] : 16'sh0000;
endmodule : lss_sel

// ==== rtl/lss_sup.sv ====
`timescale 1ns/100ps
// One level supervisor: thresholds, delay timers and state
module lss_sup
	import lss_pkg::*;
(
	input  wire logic               clk_i,  // System clock
	input  wire logic               rst_i,  // Synchronous reset
	input  wire logic               tick_i, // Sample tick
	input  wire logic               en_i,   // Source valid
	input  wire logic signed [15:0] val_i,  // Supervised signal
	input  wire lss_pkg::lss_sup_type cfg_i, // Settings
	output logic                    above_o, // Qualified state
	output logic                    act_o   // Output level after polarity
);
	logic        state;                     // 1 = above
	logic [15:0] up_cnt;                    // Rising qualification timer
	logic [15:0] dn_cnt;                    // Falling qualification timer

	// Widen to keep magnitude of the most negative value
	wire signed [17:0] sx  = {{2{val_i[15]}}, val_i};
	wire signed [17:0] mag = sx[17] ? 18'(-sx) : sx;
	wire signed [17:0] v   = cfg_i.absm ? mag : sx;
	wire signed [17:0] lv  = {{2{cfg_i.level[15]}}, cfg_i.level};
	wire signed [17:0] hy  = {{2{cfg_i.hyst[15]}}, cfg_i.hyst};
	// One threshold at the level, the other moved by hysteresis
	wire signed [17:0] th_up = cfg_i.hyst[15] ? lv : 18'(lv + hy);
	wire signed [17:0] th_dn = cfg_i.hyst[15] ? 18'(lv + hy) : lv;
	wire forced  = cfg_i.absm & cfg_i.level[15];
	wire above_c = forced | (v > th_up);
	wire below_c = ~forced & (v < th_dn);

	// Timers run only while their condition holds
	wire up_hit  = ~state & above_c;
	wire dn_hit  = state & below_c;
	wire up_done = up_cnt >= cfg_i.up_dly;
	wire dn_done = dn_cnt >= cfg_i.dn_dly;
	wire [15:0] next_up = (up_hit & ~up_done) ? up_cnt + 16'h1 : 16'h0;
	wire [15:0] next_dn = (dn_hit & ~dn_done) ? dn_cnt + 16'h1 : 16'h0;
	wire next_state = state ? ~(dn_hit & dn_done) : (up_hit & up_done);

	// State advances once per sample tick
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !en_i)
		begin
			state  <= 1'b0;
			up_cnt <= 16'h0;
			dn_cnt <= 16'h0;
		end
		else if (tick_i)
		begin
			state  <= next_state;
			up_cnt <= next_up;
			dn_cnt <= next_dn;
		end
	end

	assign above_o = state;
	assign act_o   = en_i & (cfg_i.pol ? ~state : state);
endmodule : lss_sup

// ==== rtl/lss_top.sv ====
`timescale 1ns/100ps
// Bank of level supervisors with a classic Wishbone register port
module lss_top
	import lss_pkg::*;
(
	input  wire logic                 clk_i,    // System clock, 100 MHz
	input  wire logic                 rst_i,    // Synchronous reset, high
	input  wire logic                 wb_cyc_i, // Bus cycle
	input  wire logic                 wb_stb_i, // Bus strobe
	input  wire logic                 wb_we_i,  // Write enable
	input  wire logic [11:0]          wb_adr_i, // Byte address
	input  wire logic [31:0]          wb_dat_i, // Write data
	input  wire logic [3:0]           wb_sel_i, // Byte enables
	output logic      [31:0]          wb_dat_o, // Read data
	output logic                      wb_ack_o, // Acknowledge
	input  wire logic                 tick_i,   // Measurement sample tick
	input  wire lss_pkg::lss_meas_type meas_i,  // Function block signals
	output logic      [NSUP-1:0]      status_o, // Qualified status
	output logic      [31:0]          disp_o,   // First four per block
	output logic      [NOUT-1:0]      dout_o    // Digital outputs
);
	import lss_pkg::*;

	// ****************************************************
	// Helpers
	// ****************************************************

	// Merge write data into an old word under byte enables
	function automatic logic [31:0] merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Packs the settings word of one supervisor
	function automatic logic [31:0] cfg_word(input lss_sup_type s);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[CFG_SRC_LSB +: 3] = s.src;
		r[CFG_BLK_LSB +: 4] = s.blk;
		r[CFG_ABS_BIT]      = s.absm;
		r[CFG_POL_BIT]      = s.pol;
		return r;
	endfunction : cfg_word

	// Reads one field word of one supervisor
	function automatic logic [31:0] sup_word(input lss_sup_type s,
		input logic [1:0] fld);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (fld == FLD_CFG)
		begin
			r = cfg_word(s);
		end
		else if (fld == FLD_LEVEL)
		begin
			r = {{16{s.level[15]}}, s.level};
		end
		else if (fld == FLD_HYST)
		begin
			r = {{16{s.hyst[15]}}, s.hyst};
		end
		else
		begin
			r = {s.dn_dly, s.up_dly};
		end
		return r;
	endfunction : sup_word

	// ****************************************************
	// Storage
	// ****************************************************
	lss_sup_type  sup_r  [NSUP];         // Per-supervisor settings
	lss_osel_type osel_r [NOUT];         // Output connections
	logic         ack;                   // Registered acknowledge
	logic [31:0]  rdat;                  // Registered read data
	logic [31:0]  disp;                  // Registered display word
	logic [NSUP-1:0] stat;               // Registered status word
	logic [NOUT-1:0] dout;               // Registered outputs

	// ****************************************************
	// Bus decode
	// ****************************************************
	wire        req     = wb_cyc_i & wb_stb_i & ~ack; // New request
	wire [9:0]  idx     = wb_adr_i[11:2];             // Word index
	wire        hit_sup = idx <= IDX_SUP_LAST;        // Supervisor words
	wire [4:0]  sup_n   = idx[6:2];                   // Supervisor number
	wire [1:0]  fld     = idx[1:0];                   // Word within it
	wire        hit_os  = (idx >= IDX_OSEL) &&
		(idx < IDX_OSEL + 10'(NOUT));                 // Output words
	wire [2:0]  os_n    = 3'(idx - IDX_OSEL);         // Output number
	wire        wr      = req & wb_we_i;              // Write strobe

	// Word that the addressed location holds now
	wire [31:0] cur_sup = sup_word(sup_r[sup_n], fld);
	wire [31:0] cur_os  = {23'h0, osel_r[os_n].en, 3'h0, osel_r[os_n].idx};
	wire [31:0] new_w   = merge(hit_sup ? cur_sup : cur_os, wb_dat_i, wb_sel_i);

	// Read selection; unmapped words read zero but still answer
	wire [31:0] rd_mux =
		hit_sup              ? cur_sup :
		(idx == IDX_STATUS)  ? 32'(stat) :
		(idx == IDX_DISP)    ? disp :
		hit_os               ? cur_os  : 32'h0000_0000;

	// ****************************************************
	// Bus handshake
	// ****************************************************

	// One-cycle answer; ack falls the cycle after it rose
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack  <= 1'b0;
			rdat <= 32'h0000_0000;
		end
		else
		begin
			ack  <= req;
			rdat <= req ? rd_mux : rdat;
		end
	end

	// ****************************************************
	// Settings registers
	// ****************************************************

	// Writes land on the edge that raises ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NSUP; i++)
			begin
				sup_r[i] <= lss_sup_type'(RST_WORD); // Not in use
			end
			for (int j = 0; j < NOUT; j++)
			begin
				osel_r[j] <= lss_osel_type'(RST_WORD);
			end
		end
		else if (wr && hit_sup)
		begin
			if (fld == FLD_CFG)
			begin
				sup_r[sup_n].src  <= new_w[CFG_SRC_LSB +: 3];
				sup_r[sup_n].blk  <= new_w[CFG_BLK_LSB +: 4];
				sup_r[sup_n].absm <= new_w[CFG_ABS_BIT];
				sup_r[sup_n].pol  <= new_w[CFG_POL_BIT];
			end
			else if (fld == FLD_LEVEL)
			begin
				sup_r[sup_n].level <= new_w[15:0];
			end
			else if (fld == FLD_HYST)
			begin
				sup_r[sup_n].hyst <= new_w[15:0];
			end
			else
			begin
				sup_r[sup_n].up_dly <= new_w[15:0];
				sup_r[sup_n].dn_dly <= new_w[DLY_DN_LSB +: 16];
			end
		end
		else if (wr && hit_os)
		begin
			osel_r[os_n].idx <= new_w[4:0];
			osel_r[os_n].en  <= new_w[OSEL_EN_BIT];
		end
	end

	// ****************************************************
	// Supervisors
	// ****************************************************
	logic        [NSUP-1:0] ok;          // Source selection valid
	logic        [NSUP-1:0] above;       // Qualified results
	logic        [NSUP-1:0] act;         // Results after polarity
	logic signed [15:0]     val [NSUP];  // Chosen signals

	// Each supervisor has its own selector and state
	for (genvar g = 0; g < NSUP; g++)
	begin : g_sup
		lss_sel u_sel (
			.meas_i (meas_i),
			.src_i  (sup_r[g].src),
			.blk_i  (sup_r[g].blk),
			.val_o  (val[g]),
			.ok_o   (ok[g])
		);
		lss_sup u_sup (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.tick_i  (tick_i),
			.en_i    (ok[g]),
			.val_i   (val[g]),
			.cfg_i   (sup_r[g]),
			.above_o (above[g]),
			.act_o   (act[g])
		);
	end

	// ****************************************************
	// Display selection
	// ****************************************************

	// Walk supervisors in order; the first four of a block win a slot.
	// A serial scan is cheap here since only 32 entries are searched.
	logic [31:0] next_disp;              // Display word being built
	always_comb
	begin
		logic [2:0] cnt [NBLK];
		next_disp = 32'h0000_0000;
		for (int b = 0; b < NBLK; b++)
		begin
			cnt[b] = 3'h0;
		end
		for (int i = 0; i < NSUP; i++)
		begin
			for (int b = 0; b < NBLK; b++)
			begin
				if (ok[i] && (sup_r[i].blk == 4'(b + 1)) &&
					(cnt[b] < 3'(DISP_PER_BLK)))
				begin
					next_disp[b*DISP_PER_BLK + int'(cnt[b])] = above[i];
					cnt[b] = cnt[b] + 3'h1;
				end
			end
		end
	end

	// ****************************************************
	// Digital outputs
	// ****************************************************

	// Each output copies its connected supervisor after polarity
	logic [NOUT-1:0] next_dout;          // Output levels to register
	always_comb
	begin
		for (int j = 0; j < NOUT; j++)
		begin
			next_dout[j] = osel_r[j].en & act[osel_r[j].idx];
		end
	end

	// Status comes from supervisor state, never from the outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat <= '0;
			disp <= 32'h0000_0000;
			dout <= '0;
		end
		else
		begin
			stat <= above;
			disp <= next_disp;
			dout <= next_dout;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;
	assign status_o = stat;
	assign disp_o   = disp;
	assign dout_o   = dout;
endmodule : lss_top
